// File: dma_engine.sv
// four-channel dual-address dma transfer engine with fixed-priority selection
`timescale 1ns/1ps
module dma_engine #(
	parameter int NUM_CH = 4
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [NUM_CH-1:0] desc_wr_i,
	input dma_pkg::transfer_descriptor_type [NUM_CH-1:0] desc_i,
	input wire logic [NUM_CH-1:0] ctrl_wr_i,
	input dma_pkg::channel_control_reg_type [NUM_CH-1:0] ctrl_i,
	input wire logic [NUM_CH-1:0] done_clr_i,
	input wire logic [NUM_CH-1:0] dreq_i,
	input wire logic bus_ack_i,
	input wire logic bus_err_i,
	input wire logic [31:0] bus_rdata_i,
	output logic bus_req_o,
	output dma_pkg::bus_cmd_type bus_cmd_o,
	output dma_pkg::transfer_descriptor_type [NUM_CH-1:0] desc_o,
	output dma_pkg::channel_status_reg_type [NUM_CH-1:0] status_o,
	output logic [NUM_CH-1:0] irq_o
);
	import dma_pkg::*;

	localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_READ, ST_PUSH, ST_WRITE} state_type;

	state_type state_q, state_d;
	logic [CH_W-1:0] ch_q, ch_d, win, eng_ch;
	logic [2:0] tb_q, tb_d, left_q, left_d, cnt_q, cnt_d, acc_q, acc_d, acc;
	logic [DATA_W-1:0] hold_q, hold_d;
	logic bus_req_q, bus_req_d;
	bus_cmd_type cmd_q, cmd_d;
	transfer_descriptor_type [NUM_CH-1:0] desc_all;
	channel_status_reg_type [NUM_CH-1:0] stat_all;
	transfer_descriptor_type cur, wd;
	logic [NUM_CH-1:0] want, swreq_all;
	logic found, abort, src_al, dst_al;
	logic [2:0] sb, db;
	logic eng_take, eng_ce, eng_pend, eng_release, eng_done, eng_bes, eng_bed, eng_clr_erq;
	logic eng_sar_we, eng_dar_we, eng_bcr_we;
	logic [ADDR_W-1:0] eng_sar, eng_dar;
	logic [COUNT_W-1:0] eng_bcr;
	logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready, buf_flush;
	logic [DATA_W-1:0] buf_out_data;

	// =========================================================
	// channel configuration checks
	// source wins alignment when its width is not smaller
	function automatic logic align_source(input channel_control_reg_type c);
		return c.auto_align_enable &&
			(width_bytes(c.source_width) >= width_bytes(c.dest_width));
	endfunction

	// reserved widths and misaligned pointers on checked sides
	function automatic logic config_bad(input transfer_descriptor_type d);
		logic s_al, d_al, mis;
		s_al = align_source(d.ctrl);
		d_al = d.ctrl.auto_align_enable && !s_al;
		mis = (!s_al && ((d.source_pointer[2:0] & (width_bytes(d.ctrl.source_width) - 3'h1))
			!= 3'h0)) || (!d_al && ((d.dest_pointer[2:0]
			& (width_bytes(d.ctrl.dest_width) - 3'h1)) != 3'h0));
		return (d.ctrl.source_width == WIDTH_RSVD) || (d.ctrl.dest_width == WIDTH_RSVD) || mis;
	endfunction

	// =========================================================
	// per-channel programming model
	for (genvar i = 0; i < NUM_CH; i++)
	begin : g_ch
		transfer_descriptor_type desc_q, desc_d;
		channel_status_reg_type st_q, st_d;
		logic swreq_q, swreq_d, irq_q, irq_d, mine;

		assign mine = (eng_ch == CH_W'(i));

		always_comb
		begin
			desc_d = desc_q;
			st_d = st_q;
			swreq_d = swreq_q;
			if (mine && eng_sar_we)
				desc_d.source_pointer = eng_sar;
			if (mine && eng_dar_we)
				desc_d.dest_pointer = eng_dar;
			if (mine && eng_bcr_we)
				desc_d.remaining_byte_count = eng_bcr;
			if (mine && eng_clr_erq)
				desc_d.ctrl.peripheral_trigger_enable = 1'b0;
			if (mine && eng_take)
				swreq_d = 1'b0;
			if (desc_wr_i[i])
				desc_d = desc_i[i];
			else if (ctrl_wr_i[i])
				desc_d.ctrl = ctrl_i[i];
			if ((desc_wr_i[i] && desc_i[i].ctrl.start) || (ctrl_wr_i[i] && ctrl_i[i].start))
				swreq_d = 1'b1;
			desc_d.ctrl.start = 1'b0;
			if (done_clr_i[i])
			begin
				st_d.done = 1'b0;
				st_d.source_bus_error_flag = 1'b0;
				st_d.dest_bus_error_flag = 1'b0;
				st_d.config_error = 1'b0;
			end
			if (mine && eng_release)
			begin
				st_d.busy = 1'b0;
				st_d.pending = 1'b0;
			end
			// hardware sets come last so a same-cycle bus or config error beats the clear; a completion is dropped by the abort
			if (mine && eng_take && !eng_ce)
				st_d.busy = 1'b1;
			if (mine && eng_pend)
				st_d.pending = 1'b1;
			if (mine && eng_ce)
				st_d.config_error = 1'b1;
			if (mine && (eng_done || eng_bes || eng_bed))
				st_d.done = 1'b1;
			if (mine && eng_bes)
				st_d.source_bus_error_flag = 1'b1;
			if (mine && eng_bed)
				st_d.dest_bus_error_flag = 1'b1;
			irq_d = desc_d.ctrl.completion_irq_enable && (st_d.done || st_d.config_error);
		end

		always_ff @(posedge core_clk_i or negedge nrst_i)
		begin
			if (!nrst_i)
			begin
				desc_q <= DESC_RESET;
				st_q <= STATUS_RESET;
				swreq_q <= 1'b0;
				irq_q <= 1'b0;
			end
			else
			begin
				desc_q <= desc_d;
				st_q <= st_d;
				swreq_q <= swreq_d;
				irq_q <= irq_d;
			end
		end

		assign desc_all[i] = desc_q;
		assign stat_all[i] = st_q;
		assign swreq_all[i] = swreq_q;
		assign irq_o[i] = irq_q;
		assign want[i] = !st_q.done && !st_q.config_error && (swreq_q
			|| (desc_q.ctrl.peripheral_trigger_enable && dreq_i[i]));
	end

	assign desc_o = desc_all;
	assign status_o = stat_all;
	assign bus_req_o = bus_req_q;
	assign bus_cmd_o = cmd_q;

	// =========================================================
	// arbitration
	// lowest number wins
	always_comb
	begin
		win = '0;
		found = 1'b0;
		for (int i = NUM_CH - 1; i >= 0; i--)
		begin
			if (want[i])
			begin
				win = CH_W'(i);
				found = 1'b1;
			end
		end
	end

	// =========================================================
	// transfer sequencer
	assign cur = desc_all[ch_q];
	assign wd = desc_all[win];
	assign sb = width_bytes(cur.ctrl.source_width);
	assign db = width_bytes(cur.ctrl.dest_width);
	assign src_al = align_source(cur.ctrl);
	assign dst_al = cur.ctrl.auto_align_enable && !src_al;
	// done write stops the active channel
	assign abort = (state_q != ST_IDLE) && done_clr_i[ch_q];

	// largest legal size per access, capped by side width
	always_comb
	begin
		if (state_q == ST_WRITE)
			acc = min_bytes(min_bytes(db, floor_bytes(COUNT_W'(left_q))),
				cur.ctrl.auto_align_enable ? addr_align(cur.dest_pointer[1:0]) : BYTES_4);
		else
			acc = min_bytes(min_bytes(sb, floor_bytes(COUNT_W'(left_q))),
				cur.ctrl.auto_align_enable ? addr_align(cur.source_pointer[1:0]) : BYTES_4);
	end

	always_comb
	begin
		state_d = state_q;
		ch_d = ch_q;
		tb_d = tb_q;
		left_d = left_q;
		cnt_d = cnt_q;
		acc_d = acc_q;
		hold_d = hold_q;
		bus_req_d = bus_req_q;
		cmd_d = cmd_q;
		eng_ch = (state_q == ST_IDLE) ? win : ch_q;
		{eng_take, eng_ce, eng_pend, eng_release, eng_done} = 5'h00;
		{eng_bes, eng_bed, eng_clr_erq, eng_sar_we, eng_dar_we, eng_bcr_we} = 6'h00;
		eng_sar = cur.source_pointer + ADDR_W'(acc_q);
		eng_dar = cur.dest_pointer + ADDR_W'(acc_q);
		eng_bcr = cur.remaining_byte_count - COUNT_W'(tb_q);
		buf_in_valid = 1'b0;
		buf_out_ready = 1'b0;
		buf_flush = 1'b0;
		unique case (state_q)
			ST_IDLE:
			begin
				if (found)
				begin
					eng_take = 1'b1;
					ch_d = win;
					if (config_bad(wd))
						eng_ce = 1'b1;
					else
						state_d = ST_START;
				end
			end
			ST_START:
			begin
				if (cur.remaining_byte_count == '0)
				begin
					eng_done = 1'b1;
					eng_release = 1'b1;
					state_d = ST_IDLE;
				end
				else
				begin
					// auto-aligned transfer size from address, then count
					if (!cur.ctrl.auto_align_enable)
						tb_d = (sb > db) ? sb : db;
					else
					begin
						tb_d = min_bytes(src_al ? sb : db, addr_align(src_al ?
							cur.source_pointer[1:0] : cur.dest_pointer[1:0]));
						if (cur.remaining_byte_count < ALIGN_THRESHOLD)
							tb_d = min_bytes(tb_d, floor_bytes(cur.remaining_byte_count));
					end
					left_d = tb_d;
					cnt_d = 3'h0;
					hold_d = '0;
					eng_pend = 1'b1;
					state_d = ST_READ;
				end
			end
			ST_READ:
			begin
				if (!bus_req_q)
				begin
					bus_req_d = 1'b1;
					acc_d = acc;
					cmd_d = '{we: 1'b0, addr: cur.source_pointer, size: bytes_width(acc), wdata: '0};
				end
				else if (bus_err_i)
				begin
					bus_req_d = 1'b0;
					eng_bes = 1'b1;
					eng_release = 1'b1;
					state_d = ST_IDLE;
				end
				else if (bus_ack_i)
				begin
					bus_req_d = 1'b0;
					hold_d = hold_q | ((bus_rdata_i & lane_mask(acc_q)) << {cnt_q, 3'h0});
					cnt_d = cnt_q + acc_q;
					left_d = left_q - acc_q;
					eng_sar_we = cur.ctrl.source_step_enable || src_al;
					if (left_q == acc_q)
						state_d = ST_PUSH;
				end
			end
			ST_PUSH:
			begin
				buf_in_valid = 1'b1;
				if (buf_in_ready)
				begin
					left_d = tb_q;
					cnt_d = 3'h0;
					state_d = ST_WRITE;
				end
			end
			// dest writes drain the held word
			ST_WRITE:
			begin
				if (!bus_req_q)
				begin
					if (buf_out_valid)
					begin
						bus_req_d = 1'b1;
						acc_d = acc;
						cmd_d = '{we: 1'b1, addr: cur.dest_pointer, size: bytes_width(acc),
							wdata: buf_out_data >> {cnt_q, 3'h0}};
					end
				end
				else if (bus_err_i)
				begin
					bus_req_d = 1'b0;
					buf_out_ready = 1'b1;
					eng_bed = 1'b1;
					eng_release = 1'b1;
					state_d = ST_IDLE;
				end
				else if (bus_ack_i)
				begin
					bus_req_d = 1'b0;
					cnt_d = cnt_q + acc_q;
					left_d = left_q - acc_q;
					eng_dar_we = cur.ctrl.dest_step_enable || dst_al;
					if (left_q == acc_q)
					begin
						buf_out_ready = 1'b1;
						eng_bcr_we = 1'b1;
						if (eng_bcr == '0)
						begin
							eng_done = 1'b1;
							eng_clr_erq = cur.ctrl.trigger_off_at_end;
							eng_release = 1'b1;
							state_d = ST_IDLE;
						end
						else if (cur.ctrl.cycle_steal)
						begin
							eng_release = 1'b1;
							state_d = ST_IDLE;
						end
						else
							state_d = ST_START;
					end
				end
			end
		endcase
		if (abort)
		begin
			bus_req_d = 1'b0;
			buf_flush = 1'b1;
			eng_release = 1'b1;
			{eng_sar_we, eng_dar_we, eng_bcr_we, eng_done} = 4'h0;
			state_d = ST_IDLE;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_q <= ST_IDLE;
			ch_q <= '0;
			tb_q <= 3'h0;
			left_q <= 3'h0;
			cnt_q <= 3'h0;
			acc_q <= 3'h0;
			hold_q <= '0;
			bus_req_q <= 1'b0;
			cmd_q <= CMD_RESET;
		end
		else
		begin
			state_q <= state_d;
			ch_q <= ch_d;
			tb_q <= tb_d;
			left_q <= left_d;
			cnt_q <= cnt_d;
			acc_q <= acc_d;
			hold_q <= hold_d;
			bus_req_q <= bus_req_d;
			cmd_q <= cmd_d;
		end
	end

	// =========================================================
	// holding buffer between read and write phases
	// a stalled write side blocks the push state, so no word is lost
	dma_hold_buffer #(
		.WIDTH(DATA_W),
		.DEPTH(2)
	) u_hold (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.flush_i(buf_flush),
		.in_valid_i(buf_in_valid),
		.in_ready_o(buf_in_ready),
		.in_data_i(hold_q),
		.out_valid_o(buf_out_valid),
		.out_ready_i(buf_out_ready),
		.out_data_o(buf_out_data)
	);

endmodule // dma_engine

// File: dma_pkg.sv
// shared types, encodings and helper functions for the four-channel dma engine
package dma_pkg;

	// =========================================================
	// sizes and encodings
	localparam int COUNT_W = 24;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam logic [1:0] WIDTH_LONG = 2'h0;
	localparam logic [1:0] WIDTH_BYTE = 2'h1;
	localparam logic [1:0] WIDTH_WORD = 2'h2;
	localparam logic [1:0] WIDTH_RSVD = 2'h3;
	localparam logic [2:0] BYTES_1 = 3'h1;
	localparam logic [2:0] BYTES_2 = 3'h2;
	localparam logic [2:0] BYTES_4 = 3'h4;
	localparam logic [COUNT_W-1:0] ALIGN_THRESHOLD = 24'h000010;

	// =========================================================
	// carriers
	typedef struct packed {
		logic completion_irq_enable;
		logic peripheral_trigger_enable;
		logic cycle_steal;
		logic auto_align_enable;
		logic source_step_enable;
		logic [1:0] source_width;
		logic dest_step_enable;
		logic [1:0] dest_width;
		logic trigger_off_at_end;
		logic start;
	} channel_control_reg_type;

	typedef struct packed {
		channel_control_reg_type ctrl;
		logic [ADDR_W-1:0] source_pointer;
		logic [ADDR_W-1:0] dest_pointer;
		logic [COUNT_W-1:0] remaining_byte_count;
	} transfer_descriptor_type;

	typedef struct packed {
		logic done;
		logic source_bus_error_flag;
		logic dest_bus_error_flag;
		logic config_error;
		logic busy;
		logic pending;
	} channel_status_reg_type;

	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [1:0] size;
		logic [DATA_W-1:0] wdata;
	} bus_cmd_type;

	localparam transfer_descriptor_type DESC_RESET = '0;
	localparam channel_status_reg_type STATUS_RESET = '0;
	localparam bus_cmd_type CMD_RESET = '0;

	// =========================================================
	// helpers
	function automatic logic [2:0] width_bytes(input logic [1:0] w);
		case (w)
			WIDTH_BYTE: return BYTES_1;
			WIDTH_WORD: return BYTES_2;
			default: return BYTES_4;
		endcase
	endfunction

	function automatic logic [1:0] bytes_width(input logic [2:0] b);
		case (b)
			BYTES_1: return WIDTH_BYTE;
			BYTES_2: return WIDTH_WORD;
			default: return WIDTH_LONG;
		endcase
	endfunction

	function automatic logic [2:0] addr_align(input logic [1:0] a);
		return a[0] ? BYTES_1 : (a[1] ? BYTES_2 : BYTES_4);
	endfunction

	function automatic logic [2:0] min_bytes(input logic [2:0] a, input logic [2:0] b);
		return (a < b) ? a : b;
	endfunction

	function automatic logic [2:0] floor_bytes(input logic [COUNT_W-1:0] n);
		return (n >= 24'h000004) ? BYTES_4 : ((n >= 24'h000002) ? BYTES_2 : BYTES_1);
	endfunction

	function automatic logic [DATA_W-1:0] lane_mask(input logic [2:0] b);
		case (b)
			BYTES_1: return 32'h000000FF;
			BYTES_2: return 32'h0000FFFF;
			default: return 32'hFFFFFFFF;
		endcase
	endfunction

endpackage

// File: dma_hold_buffer.sv
// small fifo holding assembled transfer data between read and write phases
`timescale 1ns/1ps
module dma_hold_buffer #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	// =========================================================
	// pointers and occupancy
	assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// wrap pointers by depth so non power of two depths stay honest
	always_comb
	begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push)
			wr_d = (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + PW'(1);
		if (pop)
			rd_d = (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + PW'(1);
		cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		if (flush_i)
		begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage carries no reset, its contents are qualified by the count
	always_ff @(posedge core_clk_i)
	begin
		if (push)
			mem_q[wr_q] <= in_data_i;
	end

endmodule // dma_hold_buffer

// File: dma_engine_props.sv
// concurrent checks on the ports of the dma engine
`timescale 1ns/1ps
module dma_engine_props #(
	parameter int NUM_CH = 4
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [NUM_CH-1:0] desc_wr_i,
	input wire logic [NUM_CH-1:0] done_clr_i,
	input wire logic bus_ack_i,
	input wire logic bus_err_i,
	input wire logic bus_req_o,
	input dma_pkg::bus_cmd_type bus_cmd_o,
	input dma_pkg::transfer_descriptor_type [NUM_CH-1:0] desc_o,
	input dma_pkg::channel_status_reg_type [NUM_CH-1:0] status_o,
	input wire logic [NUM_CH-1:0] irq_o
);
	import dma_pkg::*;
	// =========================================================
	// checks: channel 0 carries the error cases, so its flags are watched
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	AST_START_ZERO: assert property (!(desc_o[0].ctrl.start || desc_o[NUM_CH-1].ctrl.start))
		else $error("start bit read back as one");
	AST_COUNT_STEP: assert property (!$past(desc_wr_i[0]) && $changed(desc_o[0].remaining_byte_count)
		|-> ($past(desc_o[0].remaining_byte_count) - desc_o[0].remaining_byte_count)
		inside {24'h1, 24'h2, 24'h4}) else $error("byte count moved by a wrong amount");
	AST_SRC_STEP: assert property (!$past(desc_wr_i[0]) && $changed(desc_o[0].source_pointer)
		|-> ($past(desc_o[0].ctrl.source_step_enable) || $past(desc_o[0].ctrl.auto_align_enable))
		&& (desc_o[0].source_pointer - $past(desc_o[0].source_pointer)) inside {32'h1, 32'h2, 32'h4})
		else $error("source pointer stepped wrongly");
	AST_REQ_HOLD: assert property (bus_req_o && !bus_ack_i && !bus_err_i && done_clr_i == '0
		|=> bus_req_o && $stable(bus_cmd_o)) else $error("bus request changed before its answer");
	AST_REQ_DROP: assert property (bus_req_o && (bus_ack_i || bus_err_i) |=> !bus_req_o)
		else $error("bus request stayed after its answer");
	AST_DONE_ZERO: assert property ($past(desc_o[0].remaining_byte_count) != 24'h0
		&& desc_o[0].remaining_byte_count == 24'h0 && !$past(desc_wr_i[0])
		|-> ##[0:1] status_o[0].done) else $error("done missing at count zero");
	AST_RD_ERR: assert property (bus_req_o && bus_err_i && !bus_cmd_o.we
		|-> ##[1:2] status_o[0].source_bus_error_flag && status_o[0].done)
		else $error("read error not flagged");
	AST_WR_ERR: assert property (bus_req_o && bus_err_i && bus_cmd_o.we
		|-> ##[1:2] status_o[0].dest_bus_error_flag && status_o[0].done)
		else $error("write error not flagged");
	AST_PEND_READ: assert property ($rose(status_o[0].pending)
		|-> ##[0:3] bus_req_o && !bus_cmd_o.we && bus_cmd_o.addr == desc_o[0].source_pointer)
		else $error("pending without a source read");
	AST_IRQ_LEVEL: assert property (irq_o[0] == (desc_o[0].ctrl.completion_irq_enable
		&& (status_o[0].done || status_o[0].config_error)))
		else $error("interrupt level wrong");
	COV_RD_ERR: cover property (status_o[0].source_bus_error_flag);
	COV_TRIG_OFF: cover property (status_o[1].done && !desc_o[1].ctrl.peripheral_trigger_enable);
	COV_CFG_IRQ: cover property (status_o[0].config_error && irq_o[0]);
endmodule // dma_engine_props

bind dma_engine dma_engine_props #(.NUM_CH(NUM_CH)) u_props (
	.core_clk_i(core_clk_i),
	.nrst_i(nrst_i),
	.desc_wr_i(desc_wr_i),
	.done_clr_i(done_clr_i),
	.bus_ack_i(bus_ack_i),
	.bus_err_i(bus_err_i),
	.bus_req_o(bus_req_o),
	.bus_cmd_o(bus_cmd_o),
	.desc_o(desc_o),
	.status_o(status_o),
	.irq_o(irq_o)
);

// File: dma_bus_slave.sv
// behavioural system-bus slave that answers the engine and logs its writes
`timescale 1ns/1ps
module dma_bus_slave (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic bus_req_i,
	input dma_pkg::bus_cmd_type bus_cmd_i,
	input wire logic [1:0] lat_i,
	input wire logic [1:0] err_arm_i,
	output logic bus_ack_o,
	output logic bus_err_o,
	output logic [31:0] bus_rdata_o
);
	import dma_pkg::*;
	logic [1:0] wait_q;
	logic [65:0] wlog[$];
	// =========================================================
	// memory image: each byte is a fixed function of its address, upper lanes never blank
	function automatic logic [31:0] rd(input logic [31:0] a);
		logic [31:0] v;
		for (int i = 0; i < 4; i++)
			v[8*i+:8] = 8'(a + i) ^ 8'hA5;
		return v;
	endfunction
	// one answer per access after lat_i waits; data lines toggle except on a read answer
	always @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus_ack_o <= 1'b0;
			bus_err_o <= 1'b0;
			bus_rdata_o <= 32'h0;
			wait_q <= 2'h0;
		end
		else
		begin
			bus_ack_o <= 1'b0;
			bus_err_o <= 1'b0;
			bus_rdata_o <= ~bus_rdata_o;
			if (bus_ack_o && bus_req_i && bus_cmd_i.we)
				wlog.push_back({bus_cmd_i.addr, bus_cmd_i.size, bus_cmd_i.wdata});
			if (!bus_req_i)
				wait_q <= 2'h0;
			else if (!bus_ack_o && !bus_err_o)
			begin
				wait_q <= (wait_q == lat_i) ? 2'h0 : wait_q + 2'h1;
				bus_err_o <= (wait_q == lat_i) && err_arm_i[bus_cmd_i.we];
				bus_ack_o <= (wait_q == lat_i) && !err_arm_i[bus_cmd_i.we];
				if (wait_q == lat_i && !bus_cmd_i.we)
					bus_rdata_o <= rd(bus_cmd_i.addr);
			end
		end
	end
endmodule // dma_bus_slave

// File: four_channel_dual_address_dma_tb_top.sv
// self-checking bench for the four-channel dma engine
`timescale 1ns/1ps
module four_channel_dual_address_dma_tb_top;
	import dma_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] desc_wr = 4'h0, ctrl_wr = 4'h0, done_clr = 4'h0, dreq = 4'h0, irq;
	transfer_descriptor_type [3:0] desc_in = '0;
	transfer_descriptor_type [3:0] desc_out;
	channel_control_reg_type [3:0] ctrl_in = '0;
	channel_status_reg_type [3:0] stat;
	logic ack, err, req;
	logic [31:0] rdata;
	bus_cmd_type cmd;
	logic [1:0] lat = 2'h0, err_arm = 2'h0;
	int num_errors = 0, tests_run = 0;
	logic [65:0] exp_q[$];
	always #12.5 core_clk = ~core_clk;
	dma_engine #(.NUM_CH(4)) uut (.core_clk_i(core_clk), .nrst_i(rst_n), .desc_wr_i(desc_wr),
		.desc_i(desc_in), .ctrl_wr_i(ctrl_wr), .ctrl_i(ctrl_in), .done_clr_i(done_clr),
		.dreq_i(dreq), .bus_ack_i(ack), .bus_err_i(err), .bus_rdata_i(rdata), .bus_req_o(req),
		.bus_cmd_o(cmd), .desc_o(desc_out), .status_o(stat), .irq_o(irq));
	dma_bus_slave slv (.core_clk_i(core_clk), .nrst_i(rst_n), .bus_req_i(req), .bus_cmd_i(cmd),
		.lat_i(lat), .err_arm_i(err_arm), .bus_ack_o(ack), .bus_err_o(err), .bus_rdata_o(rdata));
	// =========================================================
	// shared tasks
	task automatic check(input logic [65:0] seen, input logic [65:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	function automatic bit hit(input int ch, input int what);
		case (what)
			0: return stat[ch].done === 1'b1 || stat[ch].config_error === 1'b1;
			1: return stat[ch].busy === 1'b1;
			default: return slv.wlog.size() >= 2;
		endcase
	endfunction
	// bounded wait on a channel event; running out ends the run
	task automatic wait_for(input int ch, input int what);
		int k;
		for (k = 0; k < 3000 && !hit(ch, what); k++)
			@(posedge core_clk);
		if (k == 3000)
		begin
			num_errors++;
			$display("[FAIL] %0t wait ran out", $time);
			close_out();
		end
		@(posedge core_clk);
	endtask
	task automatic prog(input int ch, input channel_control_reg_type c, input logic [31:0] sa,
		input logic [31:0] da, input logic [23:0] n);
		@(posedge core_clk);
		desc_in[ch] <= '{c, sa, da, n};
		desc_wr[ch] <= 1'b1;
		@(posedge core_clk);
		desc_wr[ch] <= 1'b0;
	endtask
	task automatic clear(input int ch);
		@(posedge core_clk);
		done_clr[ch] <= 1'b1;
		@(posedge core_clk);
		done_clr[ch] <= 1'b0;
		@(posedge core_clk);
	endtask
	// reference: read bytes packed low first; a narrow write carries the rest of its word above
	task automatic model(input int s, input int d, input logic [31:0] sa, input logic [31:0] da,
		input int n, input bit step);
		logic [7:0] b[$];
		logic [31:0] w;
		int t;
		t = (s > d) ? s : d;
		for (int p = 0; p < n; p += s)
			for (int k = 0; k < s; k++)
				b.push_back(8'(sa + (step ? p : 0) + k) ^ 8'hA5);
		for (int p = 0; p < n; p += d)
		begin
			for (int k = 0; k < 4; k++)
				w[8*k+:8] = ((p % t) + k < t) ? b[p+k] : 8'h0;
			exp_q.push_back({da + (step ? p : 0),
				(d == 1) ? WIDTH_BYTE : ((d == 2) ? WIDTH_WORD : WIDTH_LONG), w});
		end
	endtask
	task automatic cmp_log();
		check(slv.wlog.size(), exp_q.size());
		foreach (exp_q[i])
			check(slv.wlog[i], exp_q[i]);
		exp_q.delete();
		slv.wlog.delete();
	endtask
	// =========================================================
	// main sequence
	initial
	begin
		logic [1:0] wc[3] = '{WIDTH_LONG, WIDTH_BYTE, WIDTH_WORD};
		int nb[3] = '{4, 1, 2};
		int asz[7] = '{1, 2, 4, 4, 4, 4, 1};
		int n;
		channel_control_reg_type c;
		logic [31:0] sa, da;
		void'($urandom(29));
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			c = '0;
			c.start = 1'b1;
			c.source_width = wc[i%3];
			c.dest_width = wc[i/3];
			c.source_step_enable = (i != 4);
			c.dest_step_enable = (i != 4);
			sa = $urandom & 32'h0FFF_FFF0;
			da = $urandom & 32'h0FFF_FFF0;
			lat <= 2'($urandom % 4);
			// whole descriptor with start in one write
			prog(0, c, sa, da, 24'h8);
			model(nb[i%3], nb[i/3], sa, da, 8, i != 4);
			wait_for(0, 0);
			cmp_log();
			check(desc_out[0].source_pointer, sa + ((i != 4) ? 8 : 0));
			check(desc_out[0].dest_pointer, da + ((i != 4) ? 8 : 0));
			check({desc_out[0].remaining_byte_count, stat[0].done}, {24'h0, 1'b1});
			clear(0);
		end
		$display("test widths done");
		c = '0;
		c.peripheral_trigger_enable = 1'b1;
		c.cycle_steal = 1'b1;
		c.trigger_off_at_end = 1'b1;
		c.source_step_enable = 1'b1;
		c.dest_step_enable = 1'b1;
		prog(3, c, 32'h0000_1000, 32'h0000_3000, 24'h8);
		prog(1, c, 32'h0000_2000, 32'h0000_4000, 24'h8);
		model(4, 4, 32'h0000_2000, 32'h0000_4000, 8, 1);
		model(4, 4, 32'h0000_1000, 32'h0000_3000, 8, 1);
		repeat (5) @(posedge core_clk);
		check(req, 1'b0);
		dreq <= 4'hA;
		wait_for(1, 0);
		wait_for(3, 0);
		dreq <= 4'h0;
		cmp_log();
		check(desc_out[1].ctrl.peripheral_trigger_enable, 1'b0);
		c.trigger_off_at_end = 1'b0;
		prog(2, c, 32'h0000_5000, 32'h0000_6000, 24'h8);
		model(4, 4, 32'h0000_5000, 32'h0000_6000, 8, 1);
		dreq <= 4'h4;
		wait_for(2, 1);
		dreq <= 4'h0;
		repeat (20) @(posedge core_clk);
		check({desc_out[2].remaining_byte_count, stat[2].done}, {24'h4, 1'b0});
		// control write lands on a half-done channel
		c.completion_irq_enable = 1'b1;
		ctrl_in[2] <= c;
		ctrl_wr[2] <= 1'b1;
		@(posedge core_clk);
		ctrl_wr[2] <= 1'b0;
		dreq <= 4'h4;
		wait_for(2, 0);
		dreq <= 4'h0;
		cmp_log();
		check(desc_out[2].ctrl.peripheral_trigger_enable, 1'b1);
		check(irq[2], 1'b1);
		$display("test priority and cycle steal done");
		for (int i = 0; i < 2; i++)
		begin
			c = '0;
			c.start = 1'b1;
			c.completion_irq_enable = 1'b1;
			c.source_width = i ? WIDTH_LONG : WIDTH_RSVD;
			prog(0, c, i ? 32'h0000_0101 : 32'h0000_0100, 32'h0000_0200, 24'h8);
			wait_for(0, 0);
			@(posedge core_clk);
			check({stat[0].config_error, stat[0].busy, irq[0], 24'(slv.wlog.size())},
				{3'b101, 24'h0});
			clear(0);
		end
		$display("test configuration errors done");
		for (int i = 0; i < 2; i++)
		begin
			c = '0;
			c.start = 1'b1;
			c.source_step_enable = 1'b1;
			err_arm <= i ? 2'h2 : 2'h1;
			prog(0, c, 32'h0000_0300, 32'h0000_0400, 24'h8);
			wait_for(0, 0);
			err_arm <= 2'h0;
			repeat (10) @(posedge core_clk);
			check({stat[0].source_bus_error_flag, stat[0].dest_bus_error_flag, req},
				{i == 0, i == 1, 1'b0});
			check({desc_out[0].remaining_byte_count, 24'(slv.wlog.size())}, {24'h8, 24'h0});
			clear(0);
			check({stat[0].done, stat[0].source_bus_error_flag, stat[0].dest_bus_error_flag},
				3'b000);
		end
		$display("test bus errors done");
		// destination aligned, so its odd start is not a config error
		c = '0;
		c.start = 1'b1;
		c.auto_align_enable = 1'b1;
		c.source_width = WIDTH_BYTE;
		c.source_step_enable = 1'b1;
		prog(0, c, 32'h0000_0A00, 32'h0000_0B01, 24'h14);
		n = 0;
		foreach (asz[k])
		begin
			model(1, asz[k], 32'h0000_0A00 + n, 32'h0000_0B01 + n, asz[k], 1);
			n += asz[k];
		end
		wait_for(0, 0);
		cmp_log();
		check(desc_out[0].dest_pointer, 32'h0000_0B15);
		check(desc_out[0].source_pointer, 32'h0000_0A14);
		clear(0);
		$display("test auto-align done");
		c = '0;
		c.start = 1'b1;
		c.source_step_enable = 1'b1;
		c.dest_step_enable = 1'b1;
		lat <= 2'h3;
		prog(0, c, 32'h0000_0800, 32'h0000_0900, 24'h40);
		wait_for(0, 2);
		clear(0);
		n = slv.wlog.size();
		repeat (30) @(posedge core_clk);
		check({stat[0].busy, req, 24'(slv.wlog.size())}, {2'b00, 24'(n)});
		$display("test abort done");
		close_out();
	end
endmodule // four_channel_dual_address_dma_tb_top
